// >>> hw/pic_ctrl.sv
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
//
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module pic_ctrl #(
    parameter bit HAS_EXT1 = 1'b1,
    parameter bit HAS_TMRA = 1'b1
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // External request pins
    input wire logic ext_irq_pin_0_i,
    input wire logic ext_irq_pin_1_i,
    // Peripheral events, one-cycle pulses
    input wire logic timer_a_ovf_i,
    input wire logic timer_b_ovf_i,
    input wire logic timer_c_ovf_i,
    input wire logic adc_done_i,
    input wire logic serial_done_i,
    // CPU sequencer side
    input wire logic stop_mode_i,
    input wire logic instr_end_i,
    input wire logic return_from_irq_instr_i,
    input wire logic [13:0] cpu_pc_i,
    input wire logic carry_bit_i,
    input wire logic status_bit_i,
    input wire logic [9:0] cpu_sp_i,
    output logic irq_pending_o,
    output logic cpu_hold_o,
    output logic push_o,
    output pic_pkg::pic_ctx_t push_ctx_o,
    output logic [9:0] sp_nxt_o,
    output logic pc_load_o,
    output logic [13:0] pc_vec_o,
    output logic [2:0] src_idx_o,
    // Interrupt line
    output logic irq_o
);

    localparam logic [6:0] PRESENT = {5'h1F, HAS_EXT1, 1'b1} &
        ~(HAS_TMRA ? 7'h00 : 7'h04);

    //////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detect

    logic [1:0] ext0_sync_r;
    logic [1:0] ext1_sync_r;
    logic [1:0] ext_prev_r;

    // Reset to the pins' idle high level, so leaving reset makes no false edge
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ext0_sync_r <= 2'b11;
            ext1_sync_r <= 2'b11;
            ext_prev_r <= 2'b11;
        end else begin
            ext0_sync_r <= {ext0_sync_r[0], ext_irq_pin_0_i};
            ext1_sync_r <= {ext1_sync_r[0], ext_irq_pin_1_i};
            ext_prev_r <= {ext1_sync_r[1], ext0_sync_r[1]};
        end
    end

    wire ext0_fall = ext_prev_r[0] & ~ext0_sync_r[1];
    wire ext1_fall = ext_prev_r[1] & ~ext1_sync_r[1];

    wire [6:0] hw_set = PRESENT & {serial_done_i, adc_done_i, timer_c_ovf_i,
        timer_b_ovf_i, timer_a_ovf_i, ext1_fall, ext0_fall};

    //////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave

    logic wr_pend_r;
    logic rd_pend_r;
    logic [7:0] addr_r;

    // Compares the latched word address against one register offset
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
        return (a == off);
    endfunction : reg_hit

    wire bus_take = hsel_i & hready_i & htrans_i[1];
    wire wr_flags = wr_pend_r & reg_hit(addr_r, pic_pkg::ADDR_FLAGS);
    wire wr_masks = wr_pend_r & reg_hit(addr_r, pic_pkg::ADDR_MASKS);
    wire wr_ctrl = wr_pend_r & reg_hit(addr_r, pic_pkg::ADDR_CTRL);
    wire wr_irq_en = wr_pend_r & reg_hit(addr_r, pic_pkg::ADDR_IRQ_EN);
    wire wr_irq_clr = wr_pend_r & reg_hit(addr_r, pic_pkg::ADDR_IRQ_CLR);

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r <= 8'h00;
        end else begin
            wr_pend_r <= bus_take & hwrite_i;
            rd_pend_r <= bus_take & ~hwrite_i;
            if (bus_take) begin
                addr_r <= {haddr_i[7:2], 2'b00};
            end
        end
    end

    // Every register answers at once, so the slave never inserts wait states
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    //////////////////////////////////////////////////////////////////////////
    // Flags, masks, global enable

    logic [6:0] flags_r;
    logic [6:0] flags_nxt;
    logic [6:0] masks_r;
    logic [6:0] masks_nxt;
    logic gie_r;
    logic gie_nxt;
    logic accept;

    // Software may only write zero; set beats clear
    assign flags_nxt = wr_flags ?
        ((flags_r & hwdata_i[6:0]) | hw_set) : (flags_r | hw_set);
    // Absent sources stay masked whatever software writes
    assign masks_nxt = wr_masks ? (hwdata_i[6:0] | ~PRESENT) : masks_r;

    // Accept is applied last, so it wins over a return or a software write
    always_comb begin
        gie_nxt = gie_r;
        if (wr_ctrl) begin
            gie_nxt = hwdata_i[0];
        end
        if (return_from_irq_instr_i) begin
            gie_nxt = 1'b1;
        end
        if (accept) begin
            gie_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i || stop_mode_i) begin
            flags_r <= pic_pkg::FLAGS_RST;
            masks_r <= pic_pkg::MASKS_RST;
            gie_r <= pic_pkg::GIE_RST;
        end else begin
            flags_r <= flags_nxt;
            masks_r <= masks_nxt;
            gie_r <= gie_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Priority selection

    wire [6:0] presented = flags_r & ~masks_r;
    wire prio_any;
    wire [2:0] prio_idx;

    pic_prio #(
        .N(pic_pkg::NUM_SRC)
    ) u_prio (
        .req_i(presented),
        .any_o(prio_any),
        .idx_o(prio_idx)
    );

    assign irq_pending_o = prio_any;

    //////////////////////////////////////////////////////////////////////////
    // Acceptance sequence

    pic_pkg::pic_state_t state_r;
    pic_pkg::pic_state_t state_nxt;
    logic [2:0] src_r;
    logic push_r;
    logic pc_load_r;
    pic_pkg::pic_ctx_t ctx_r;
    logic [9:0] sp_r;
    logic [13:0] vec_r;

    assign accept = (state_r == pic_pkg::ST_IDLE) & gie_r & prio_any;

    always_comb begin
        state_nxt = pic_pkg::ST_IDLE;
        case (state_r)
            pic_pkg::ST_IDLE: begin
                if (accept) begin
                    state_nxt = pic_pkg::ST_WAIT;
                end else begin
                    state_nxt = pic_pkg::ST_IDLE;
                end
            end
            pic_pkg::ST_WAIT: begin
                // The sequencer may need several cycles to finish its instruction
                if (instr_end_i) begin
                    state_nxt = pic_pkg::ST_SAVE;
                end else begin
                    state_nxt = pic_pkg::ST_WAIT;
                end
            end
            pic_pkg::ST_SAVE: begin
                state_nxt = pic_pkg::ST_VEC;
            end
            pic_pkg::ST_VEC: begin
                state_nxt = pic_pkg::ST_IDLE;
            end
            default: begin
                // An illegal code falls back to idle rather than locking up
                state_nxt = pic_pkg::ST_IDLE;
            end
        endcase
    end

    wire [13:0] vec_calc = pic_pkg::VEC_BASE +
        14'(pic_pkg::VEC_STEP * {11'h000, src_r});

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state_r <= pic_pkg::ST_IDLE;
            src_r <= 3'h0;
            push_r <= 1'b0;
            pc_load_r <= 1'b0;
            ctx_r <= '0;
            sp_r <= 10'h000;
            vec_r <= 14'h0000;
        end else begin
            state_r <= state_nxt;
            push_r <= 1'b0;
            pc_load_r <= 1'b0;
            if (accept) begin
                src_r <= prio_idx;
            end
            // Context is captured once the current instruction ends
            if (state_r == pic_pkg::ST_WAIT && instr_end_i) begin
                ctx_r <= '{pc: cpu_pc_i, carry_bit: carry_bit_i,
                    status_bit: status_bit_i};
                sp_r <= cpu_sp_i - pic_pkg::SP_DEC;
                push_r <= 1'b1;
            end
            // Enable was already dropped at accept, so vectoring follows the save
            if (state_r == pic_pkg::ST_SAVE) begin
                vec_r <= vec_calc;
                pc_load_r <= 1'b1;
            end
        end
    end

    assign cpu_hold_o = (state_r != pic_pkg::ST_IDLE);
    assign push_o = push_r;
    assign push_ctx_o = ctx_r;
    assign sp_nxt_o = sp_r;
    assign pc_load_o = pc_load_r;
    assign pc_vec_o = vec_r;
    assign src_idx_o = src_r;

    //////////////////////////////////////////////////////////////////////////
    // Event status and interrupt line

    logic [1:0] evt_r;
    logic [1:0] evt_en_r;
    wire [1:0] evt_set = {return_from_irq_instr_i, accept};

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            evt_r <= 2'b00;
            evt_en_r <= 2'b00;
        end else begin
            // Set beats clear, so an event in the clearing cycle is not lost
            evt_r <= (wr_irq_clr ? (evt_r & ~hwdata_i[1:0]) : evt_r) | evt_set;
            if (wr_irq_en) begin
                evt_en_r <= hwdata_i[1:0];
            end
        end
    end

    assign irq_o = |(evt_r & evt_en_r);

    //////////////////////////////////////////////////////////////////////////
    // Read data

    logic [31:0] rdata_nxt;

    always_comb begin
        case (addr_r)
            pic_pkg::ADDR_FLAGS: begin
                rdata_nxt = {25'h0, flags_r};
            end
            pic_pkg::ADDR_MASKS: begin
                rdata_nxt = {25'h0, masks_r};
            end
            pic_pkg::ADDR_CTRL: begin
                rdata_nxt = {31'h0, gie_r};
            end
            pic_pkg::ADDR_STAT: begin
                rdata_nxt = {22'h0, prio_any, state_r, src_r, evt_r};
            end
            pic_pkg::ADDR_IRQ_EN: begin
                rdata_nxt = {30'h0, evt_en_r};
            end
            default: begin
                rdata_nxt = 32'h0000_0000;
            end
        endcase
    end

    // Muxed from live registers, so a write that just landed reads back at once
    assign hrdata_o = rd_pend_r ? rdata_nxt : 32'h0000_0000;

endmodule : pic_ctrl

`default_nettype wire

// >>> hw/pic_pkg.sv
`default_nettype none

package pic_pkg;

    // Source indices in fixed priority order, 0 ranks highest
    localparam int NUM_SRC = 7;
    localparam int SRC_EXT0 = 0;
    localparam int SRC_EXT1 = 1;
    localparam int SRC_TMRA = 2;
    localparam int SRC_TMRB = 3;
    localparam int SRC_TMRC = 4;
    localparam int SRC_ADC = 5;
    localparam int SRC_SER = 6;

    // Register byte addresses
    localparam logic [7:0] ADDR_FLAGS = 8'h00;
    localparam logic [7:0] ADDR_MASKS = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h14;

    // Values after reset
    localparam logic [6:0] FLAGS_RST = 7'h00;
    localparam logic [6:0] MASKS_RST = 7'h7F;
    localparam logic GIE_RST = 1'b0;

    // Vector base and spacing in program words
    localparam logic [13:0] VEC_BASE = 14'h0002;
    localparam logic [13:0] VEC_STEP = 14'h0002;

    // Stack pointer decrement per accepted interrupt
    localparam logic [9:0] SP_DEC = 10'h004;

    // Event status bits of the interrupt output
    localparam int EVT_ACCEPT = 0;
    localparam int EVT_RETURN = 1;
    localparam int NUM_EVT = 2;

    typedef struct packed {
        logic [13:0] pc;
        logic carry_bit;
        logic status_bit;
    } pic_ctx_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WAIT = 4'b0010,
        ST_SAVE = 4'b0100,
        ST_VEC = 4'b1000
    } pic_state_t;

endpackage : pic_pkg

`default_nettype wire

// >>> hw/pic_prio.sv
`timescale 1ns/10ps
`default_nettype none

module pic_prio #(
    parameter int N = 7
) (
    // Presented requests
    input wire logic [N-1:0] req_i,
    // Grant
    output logic any_o,
    output logic [2:0] idx_o
);

    function automatic logic [2:0] first_set(input logic [N-1:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : first_set

    // Lowest index wins; others are left untouched
    assign any_o = |req_i;
    assign idx_o = first_set(req_i);

endmodule : pic_prio

`default_nettype wire

// >>> verification/pic_ctrl_checker.sv
`timescale 1ns/10ps
`default_nettype none
module pic_ctrl_checker (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic stop_mode_i,
    input wire logic instr_end_i,
    input wire logic return_from_irq_instr_i,
    input wire logic [13:0] cpu_pc_i,
    input wire logic carry_bit_i,
    input wire logic status_bit_i,
    input wire logic [9:0] cpu_sp_i,
    input wire logic irq_pending_o,
    input wire logic cpu_hold_o,
    input wire logic push_o,
    input wire pic_pkg::pic_ctx_t push_ctx_o,
    input wire logic [9:0] sp_nxt_o,
    input wire logic pc_load_o,
    input wire logic [13:0] pc_vec_o,
    input wire logic [2:0] src_idx_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (srst_i);
    sequence s_save;
        push_o ##1 pc_load_o;
    endsequence
    sequence s_vec_done;
        pc_load_o ##1 !return_from_irq_instr_i;
    endsequence
    property p_save; push_o |-> s_save; endproperty
    property p_cause; push_o |-> $past(instr_end_i) && $past(cpu_hold_o); endproperty
    property p_sp; push_o |-> sp_nxt_o == $past(cpu_sp_i) - pic_pkg::SP_DEC; endproperty
    property p_ctx;
        push_o |-> push_ctx_o == {$past(cpu_pc_i), $past(carry_bit_i), $past(status_bit_i)};
    endproperty
    property p_vec;
        pc_load_o |-> pc_vec_o == pic_pkg::VEC_BASE + {10'h000, src_idx_o, 1'b0};
    endproperty
    property p_accept; $rose(cpu_hold_o) |-> $past(irq_pending_o); endproperty
    property p_stop; stop_mode_i |=> !irq_pending_o; endproperty
    property p_blocked; s_vec_done |=> !cpu_hold_o; endproperty
    a_save: assert property (p_save) else $error("no vector load after push");
    a_cause: assert property (p_cause) else $error("push before instruction end");
    a_sp: assert property (p_sp) else $error("stack pointer not lowered by four");
    a_ctx: assert property (p_ctx) else $error("saved context wrong");
    a_vec: assert property (p_vec) else $error("vector does not match source");
    a_accept: assert property (p_accept) else $error("accept without request");
    a_stop: assert property (p_stop) else $error("request left after stop");
    a_blocked: assert property (p_blocked) else $error("accept while disabled");
endmodule : pic_ctrl_checker
bind pic_ctrl pic_ctrl_checker u_chk (.mclk_i(mclk_i), .srst_i(srst_i),
    .stop_mode_i(stop_mode_i), .instr_end_i(instr_end_i),
    .return_from_irq_instr_i(return_from_irq_instr_i), .cpu_pc_i(cpu_pc_i),
    .carry_bit_i(carry_bit_i), .status_bit_i(status_bit_i), .cpu_sp_i(cpu_sp_i),
    .irq_pending_o(irq_pending_o), .cpu_hold_o(cpu_hold_o), .push_o(push_o),
    .push_ctx_o(push_ctx_o), .sp_nxt_o(sp_nxt_o), .pc_load_o(pc_load_o),
    .pc_vec_o(pc_vec_o), .src_idx_o(src_idx_o));
`default_nettype wire

// >>> verification/pic_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module pic_cpu_model (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // Controller side
    input wire logic push_i,
    input wire logic [9:0] sp_nxt_i,
    input wire logic pc_load_i,
    input wire logic [13:0] pc_vec_i,
    input wire logic ret_cmd_i,
    output logic instr_end_o,
    output logic ret_o,
    output logic [13:0] pc_o,
    output logic [9:0] sp_o,
    output logic carry_o
);
    logic [1:0] wait_r;
    logic slow_r;
    logic fin;
    // Instructions alternate one and four cycles long
    assign fin = (wait_r == 2'd0);
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            {instr_end_o, ret_o, carry_o, slow_r, wait_r} <= '0;
            pc_o <= 14'h0000;
            sp_o <= 10'h3F0;
        end else begin
            ret_o <= ret_cmd_i;
            carry_o <= ~carry_o;
            instr_end_o <= fin;
            wait_r <= fin ? {slow_r, slow_r} : wait_r - 2'd1;
            slow_r <= slow_r ^ fin;
            // Vector holds a long jump, so the handler follows the vector
            pc_o <= pc_load_i ? pc_vec_i : pc_o + 14'h0001;
            if (push_i) sp_o <= sp_nxt_i;
            else if (ret_o) sp_o <= sp_o + 10'h004;
        end
    end
endmodule : pic_cpu_model
`default_nettype wire

// >>> verification/priority_interrupt_controller_bench.sv
`timescale 1ns/10ps
`default_nettype none
module priority_interrupt_controller_bench;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic stop = 1'b0;
    logic ret_cmd = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [1:0] pins = 2'b11;
    logic [4:0] ev = 5'h00;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] hrdata_red;
    logic [31:0] q_red;
    logic hrdy, iend, ret, carry, hold, push, pcl, pend, irq, hresp;
    logic [13:0] pc, vec;
    logic [9:0] sp, spn;
    logic [2:0] src;
    pic_pkg::pic_ctx_t ctx;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    always #25 mclk = ~mclk;
    pic_ctrl DUT (.mclk_i(mclk), .srst_i(srst), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
        .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
        .ext_irq_pin_0_i(pins[0]), .ext_irq_pin_1_i(pins[1]), .timer_a_ovf_i(ev[0]),
        .timer_b_ovf_i(ev[1]), .timer_c_ovf_i(ev[2]), .adc_done_i(ev[3]),
        .serial_done_i(ev[4]), .stop_mode_i(stop), .instr_end_i(iend),
        .return_from_irq_instr_i(ret), .cpu_pc_i(pc), .carry_bit_i(carry),
        .status_bit_i(pc[0]), .cpu_sp_i(sp), .irq_pending_o(pend), .cpu_hold_o(hold),
        .push_o(push), .push_ctx_o(ctx), .sp_nxt_o(spn), .pc_load_o(pcl),
        .pc_vec_o(vec), .src_idx_o(src), .irq_o(irq));
    // Reduced variant: no second pin, no first timer; shares the bus and the CPU
    pic_ctrl #(.HAS_EXT1(1'b0), .HAS_TMRA(1'b0)) DUT_RED (.mclk_i(mclk), .srst_i(srst),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata_red),
        .hreadyout_o(), .hresp_o(), .ext_irq_pin_0_i(pins[0]), .ext_irq_pin_1_i(pins[1]),
        .timer_a_ovf_i(ev[0]), .timer_b_ovf_i(ev[1]), .timer_c_ovf_i(ev[2]),
        .adc_done_i(ev[3]), .serial_done_i(ev[4]), .stop_mode_i(stop), .instr_end_i(iend),
        .return_from_irq_instr_i(ret), .cpu_pc_i(pc), .carry_bit_i(carry),
        .status_bit_i(pc[0]), .cpu_sp_i(sp), .irq_pending_o(), .cpu_hold_o(), .push_o(),
        .push_ctx_o(), .sp_nxt_o(), .pc_load_o(), .pc_vec_o(), .src_idx_o(), .irq_o());
    pic_cpu_model u_cpu (.mclk_i(mclk), .srst_i(srst), .push_i(push), .sp_nxt_i(spn),
        .pc_load_i(pcl), .pc_vec_i(vec), .ret_cmd_i(ret_cmd), .instr_end_o(iend),
        .ret_o(ret), .pc_o(pc), .sp_o(sp), .carry_o(carry));
    ////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 32'(a)};
        @(posedge mclk);
        while (hrdy !== 1'b1) @(posedge mclk);
        {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
        @(posedge mclk);
        while (hrdy !== 1'b1) @(posedge mclk);
        q = hrdata;
        q_red = hrdata_red;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask : rd
    task automatic idle_hold(input logic [31:0] e);
        repeat (8) @(posedge mclk);
        chk(32'(hold), e);
    endtask : idle_hold
    ////////////////////////////////////////
    task automatic t_reset;
        rd(pic_pkg::ADDR_MASKS, 32'h7F);
        chk(q_red, 32'h7F);
        chk(32'(hresp), 32'h0);
        rd(pic_pkg::ADDR_FLAGS, 32'h0);
        rd(pic_pkg::ADDR_CTRL, 32'h0);
        wr(8'h18, 32'hFFFF_FFFF);
        rd(8'h18, 32'h0);
        $display("reset test done");
    endtask : t_reset
    task automatic t_pins;
        for (int i = 0; i < 2; i++) begin
            pins[i] <= 1'b0;
            repeat (6) @(posedge mclk);
            rd(pic_pkg::ADDR_FLAGS, 32'h1 << i);
            pins[i] <= 1'b1;
            wr(pic_pkg::ADDR_FLAGS, 32'h0);
            repeat (6) @(posedge mclk);
            rd(pic_pkg::ADDR_FLAGS, 32'h0);
        end
        $display("pin test done");
    endtask : t_pins
    task automatic t_gate;
        pins <= 2'b00;
        ev <= 5'h1F;
        @(posedge mclk);
        ev <= 5'h00;
        repeat (6) @(posedge mclk);
        rd(pic_pkg::ADDR_FLAGS, 32'h7F);
        chk(q_red, 32'h79);
        wr(pic_pkg::ADDR_CTRL, 32'h1);
        idle_hold(32'h0);
        wr(pic_pkg::ADDR_CTRL, 32'h0);
        wr(pic_pkg::ADDR_MASKS, 32'h0);
        rd(pic_pkg::ADDR_MASKS, 32'h0);
        chk(q_red, 32'h06);
        rd(pic_pkg::ADDR_STAT, 32'h0000_0220);
        idle_hold(32'h0);
        chk(32'(pend), 32'h1);
        $display("gating test done");
    endtask : t_gate
    task automatic t_prio;
        int n;
        wr(pic_pkg::ADDR_IRQ_EN, 32'h1);
        wr(pic_pkg::ADDR_CTRL, 32'h1);
        for (int i = 0; i < pic_pkg::NUM_SRC; i++) begin
            n = 0;
            while (pcl !== 1'b1 && n < 60) begin
                @(posedge mclk);
                n++;
            end
            chk(32'(pcl), 32'h1);
            chk(32'(src), i);
            chk(32'(vec), 32'(pic_pkg::VEC_BASE) + 32'(pic_pkg::VEC_STEP) * i);
            rd(pic_pkg::ADDR_CTRL, 32'h0);
            rd(pic_pkg::ADDR_FLAGS, 32'h7F & (32'h7F << i));
            if (i == 0) begin
                chk(32'(irq), 32'h1);
                wr(pic_pkg::ADDR_IRQ_EN, 32'h0);
                @(posedge mclk);
                chk(32'(irq), 32'h0);
                wr(pic_pkg::ADDR_IRQ_EN, 32'h1);
                wr(pic_pkg::ADDR_IRQ_CLR, 32'h1);
                @(posedge mclk);
                chk(32'(irq), 32'h0);
            end
            wr(pic_pkg::ADDR_FLAGS, 32'h7F & ~(32'h1 << i));
            ret_cmd <= 1'b1;
            @(posedge mclk);
            ret_cmd <= 1'b0;
        end
        $display("priority test done");
    endtask : t_prio
    task automatic t_stop;
        wr(pic_pkg::ADDR_MASKS, 32'h7F);
        // Serial event lands in the same cycle as the clearing write
        fork
            wr(pic_pkg::ADDR_FLAGS, 32'h0);
            begin
                @(posedge mclk);
                ev <= 5'h10;
                @(posedge mclk);
                ev <= 5'h00;
            end
        join
        rd(pic_pkg::ADDR_FLAGS, 32'h40);
        rd(pic_pkg::ADDR_CTRL, 32'h1);
        ev <= 5'h1F;
        @(posedge mclk);
        {ev, stop} <= {5'h00, 1'b1};
        repeat (2) @(posedge mclk);
        stop <= 1'b0;
        rd(pic_pkg::ADDR_FLAGS, 32'h0);
        rd(pic_pkg::ADDR_CTRL, 32'h0);
        wr(pic_pkg::ADDR_MASKS, 32'h0);
        ev <= 5'h1F;
        @(posedge mclk);
        {ev, stop} <= {5'h00, 1'b1};
        @(posedge mclk);
        stop <= 1'b0;
        rd(pic_pkg::ADDR_MASKS, 32'h7F);
        rd(pic_pkg::ADDR_FLAGS, 32'h0);
        chk(32'(pend), 32'h0);
        $display("stop test done");
    endtask : t_stop
    ////////////////////////////////////////
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            $display("CHECK FAILED at %0t: timeout", $time);
            close_out();
        end
    end
    initial begin
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        t_reset();
        t_pins();
        t_gate();
        t_prio();
        t_stop();
        close_out();
    end
endmodule : priority_interrupt_controller_bench
`default_nettype wire
